// File: pas_params.svh
// Offsets, field positions, reset values and timing counts of the PWM auto-shutdown block
// How it works
// - Shutdown control bit 7 reads the flag, which can read zero while outputs stay held until the next period start.
// - Bits 6-4 pick the sources: comparators, fault pin, or combinations of them.
// - During shutdown pair A/C goes low (00), high (01) or floats (1x).
// - During shutdown pair B/D goes low (00), high (01) or floats (1x).
// - With auto restart, the flag follows the cause and clears when it goes; a flag forced by software stays set.
// - Without auto restart, the flag stays set until software clears it.
// - After the flag clears, PWM output resumes only at the next period start.
// - Software writes to the flag are ignored while a shutdown cause is active.
// - Comparator sources are levels; the flag cannot clear while one still signals.
// - Software writing one to the flag forces shutdown without any source event.
// - Two low mode bits choose active-low polarity for pair A/C and pair B/D.
// - Software waits one full PWM cycle, shown by the period flag, before enabling pins.
// - Reset makes every pin an input and every register its reset value.
// - Hardware sets the flag whenever an enabled source becomes active.
// - A shutdown event moves the pins to their shutdown levels one clock after the synchronised source or the flag shows it.
// - A flag set at a period start holds shutdown for that whole period.
`ifndef PAS_PARAMS_SVH
`define PAS_PARAMS_SVH

// ==========================================================
// Register offsets (byte addresses)
`define PAS_OFF_SHDN 8'h00
`define PAS_OFF_RESTART 8'h04
`define PAS_OFF_MODE 8'h08
`define PAS_OFF_DIR 8'h0c
`define PAS_OFF_STATUS 8'h10

// ==========================================================
// Field positions
`define PAS_FLAG_BIT 7
`define PAS_SRC_HI 6
`define PAS_SRC_LO 4
`define PAS_AC_HI 3
`define PAS_AC_LO 2
`define PAS_BD_HI 1
`define PAS_BD_LO 0
`define PAS_RESTART_BIT 7
`define PAS_DEAD_HI 6
`define PAS_POL_AC_BIT 0
`define PAS_POL_BD_BIT 1
`define PAS_ST_PERIOD_BIT 0
`define PAS_ST_SRC_BIT 1
`define PAS_ST_HELD_BIT 2
`define PAS_ST_FORCED_BIT 3
`define PAS_ST_COMP1_BIT 4
`define PAS_ST_COMP2_BIT 5
`define PAS_ST_FAULT_BIT 6

// ==========================================================
// Reset values
`define PAS_SHDN_RST 8'h00
`define PAS_RESTART_RST 8'h00
`define PAS_MODE_RST 8'h00
`define PAS_DIR_RST 4'hf

// ==========================================================
// Timing
`define PAS_SYNC_STAGES 2

`endif

// File: pas_pkg.sv
// Types shared by the PWM auto-shutdown block
package pas_pkg;

	// ==========================================================
	// Shutdown source selection codes
	typedef enum logic [2:0] {
		PAS_SRC_NONE = 3'h0,
		PAS_SRC_CMP1 = 3'h1,
		PAS_SRC_CMP2 = 3'h2,
		PAS_SRC_CMP_ANY = 3'h3,
		PAS_SRC_FAULT = 3'h4,
		PAS_SRC_FAULT_CMP1 = 3'h5,
		PAS_SRC_FAULT_CMP2 = 3'h6,
		PAS_SRC_ALL = 3'h7
	} pas_src_t;

	// ==========================================================
	// Synchronised source levels; comp1 and comp2 active high, fault active low
	typedef struct packed {
		logic comp1;
		logic comp2;
		logic fault;
	} pas_src_lvl_t;

	// ==========================================================
	// Whole state of the top module
	typedef struct packed {
		logic ack;
		logic [31:0] rdata;
		logic flag;
		logic forced;
		logic held;
		pas_src_t src_sel;
		logic [1:0] ac_level;
		logic [1:0] bd_level;
		logic restart;
		logic [6:0] deadband;
		logic [7:0] mode;
		logic [3:0] dir;
		logic period_flag;
		logic [3:0] pin;
		logic [3:0] oe;
	} pas_state_t;

endpackage

// File: pas_sync.sv
// Two-stage synchroniser for asynchronous input levels
`timescale 1ns/100ps
`include "pas_params.svh"
module pas_sync
	import pas_pkg::*;
#(
	parameter int WIDTH = 3
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_b_in,
	// Levels
	input wire logic [WIDTH-1:0] async_in,
	input wire logic [WIDTH-1:0] rst_val_in,
	output logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] stage1;

	if (WIDTH < 1) begin : g_bad_width
		$error("pas_sync: WIDTH must be at least one");
	end

	// First stage is read by the second stage only
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			stage1 <= '0;
			sync_out <= '0;
		end else begin
			stage1 <= async_in ^ rst_val_in;
			sync_out <= stage1 ^ rst_val_in;
		end
	end

endmodule

// File: pas_pin_level.sv
// Next level and enable of one PWM output pin
`timescale 1ns/100ps
`include "pas_params.svh"
module pas_pin_level
	import pas_pkg::*;
(
	// Control
	input wire logic shutdown_in,
	input wire logic [1:0] level_in,
	input wire logic active_low_in,
	input wire logic dir_input_in,
	// Signal
	input wire logic pwm_in,
	output logic pin_out,
	output logic oe_out
);

	always_comb begin
		if (shutdown_in) begin
			pin_out = level_in[0] & ~level_in[1];
			oe_out = ~level_in[1] & ~dir_input_in;
		end else begin
			pin_out = pwm_in ^ active_low_in;
			oe_out = ~dir_input_in;
		end
	end

endmodule

// File: pas_top.sv
// PWM auto-shutdown and auto-restart with a Wishbone register slave
//
// The implementer's own choices: register access over Wishbone and the register offsets.
`timescale 1ns/100ps
`include "pas_params.svh"
module pas_top
	import pas_pkg::*;
#(
	parameter int ADDR_W = 8,
	parameter int PINS = 4
) (
	// Clock and reset
	input wire logic CLK_IN,
	input wire logic RST_B_IN,
	// Wishbone slave
	input wire logic WB_CYC_IN,
	input wire logic WB_STB_IN,
	input wire logic WB_WE_IN,
	input wire logic [ADDR_W-1:0] WB_ADR_IN,
	input wire logic [3:0] WB_SEL_IN,
	input wire logic [31:0] WB_DAT_IN,
	output logic [31:0] WB_DAT_OUT,
	output logic WB_ACK_OUT,
	// PWM generator and period timer, same clock
	input wire logic [PINS-1:0] PWM_IN,
	input wire logic PERIOD_START_IN,
	// Asynchronous shutdown sources
	input wire logic COMP1_IN,
	input wire logic COMP2_IN,
	input wire logic FAULT_B_IN,
	// Output pins A, B, C, D
	output logic [PINS-1:0] PWM_PIN_OUT,
	output logic [PINS-1:0] PWM_OE_OUT,
	// Status
	output logic SHUTDOWN_OUT
);

	// ==========================================================
	// Declarations
	pas_state_t s;
	pas_state_t next_s;
	pas_src_lvl_t src_lvl;
	logic src_active;
	logic req;
	logic wr_go;
	logic wr_lane0;
	logic hit_shdn;
	logic hit_restart;
	logic hit_mode;
	logic hit_dir;
	logic hit_status;
	logic shdn_wr;
	logic shutdown_now;
	logic [PINS-1:0] pin_val;
	logic [PINS-1:0] pin_oe;
	logic [7:0] wbyte;

	// Refuse sizes the decode and pin pairing cannot serve
	if (ADDR_W < 8) begin : g_bad_addr_w
		$error("pas_top: ADDR_W must be at least 8");
	end
	if (PINS != 4) begin : g_bad_pins
		$error("pas_top: PINS must be 4");
	end

	// ==========================================================
	// Source synchronisation
	pas_sync #(
		.WIDTH(3)
	) u_sync (
		.clk_in(CLK_IN),
		.rst_b_in(RST_B_IN),
		.async_in({COMP1_IN, COMP2_IN, FAULT_B_IN}),
		.rst_val_in(3'h1),
		.sync_out({src_lvl.comp1, src_lvl.comp2, src_lvl.fault})
	);

	// ==========================================================
	// Source selection
	function automatic logic select_src(input pas_src_t sel, input logic c1, input logic c2,
		input logic flt);
		logic r;
		r = 1'b0;
		unique case (sel)
			PAS_SRC_NONE: r = 1'b0;
			PAS_SRC_CMP1: r = c1;
			PAS_SRC_CMP2: r = c2;
			PAS_SRC_CMP_ANY: r = c1 | c2;
			PAS_SRC_FAULT: r = flt;
			PAS_SRC_FAULT_CMP1: r = flt | c1;
			PAS_SRC_FAULT_CMP2: r = flt | c2;
			PAS_SRC_ALL: r = flt | c1 | c2;
		endcase
		return r;
	endfunction

	// Fault pin is active low
	always_comb begin
		src_active = select_src(s.src_sel, src_lvl.comp1, src_lvl.comp2,
			~src_lvl.fault);
	end

	// ==========================================================
	// Bus decode
	always_comb begin
		req = WB_CYC_IN & WB_STB_IN & ~s.ack;
		wr_go = WB_CYC_IN & WB_STB_IN & WB_WE_IN & s.ack;
		wr_lane0 = wr_go & WB_SEL_IN[0];
		wbyte = WB_DAT_IN[7:0];
		hit_shdn = WB_ADR_IN == ADDR_W'(`PAS_OFF_SHDN);
		hit_restart = WB_ADR_IN == ADDR_W'(`PAS_OFF_RESTART);
		hit_mode = WB_ADR_IN == ADDR_W'(`PAS_OFF_MODE);
		hit_dir = WB_ADR_IN == ADDR_W'(`PAS_OFF_DIR);
		hit_status = WB_ADR_IN == ADDR_W'(`PAS_OFF_STATUS);
		shdn_wr = wr_lane0 & hit_shdn;
	end

	// ==========================================================
	// Pin level per pin; even pins form pair A/C, odd pins pair B/D
	always_comb begin
		shutdown_now = s.held | s.flag | src_active;
	end

	genvar gi;
	generate
		for (gi = 0; gi < PINS; gi++) begin : g_pin
			pas_pin_level u_pin (
				.shutdown_in(shutdown_now),
				.level_in((gi % 2 == 0) ? s.ac_level : s.bd_level),
				.active_low_in((gi % 2 == 0) ? s.mode[`PAS_POL_AC_BIT] : s.mode[`PAS_POL_BD_BIT]),
				.dir_input_in(s.dir[gi]),
				.pwm_in(PWM_IN[gi]),
				.pin_out(pin_val[gi]),
				.oe_out(pin_oe[gi])
			);
		end
	endgenerate

	// ==========================================================
	// Next state
	always_comb begin
		next_s = s;

		// Acknowledge one cycle after the request, drop it the cycle after
		next_s.ack = req;

		// Read data captured when the request is taken
		if (req) begin
			next_s.rdata = 32'h0;
			if (hit_shdn) begin
				next_s.rdata[`PAS_FLAG_BIT] = s.flag;
				next_s.rdata[`PAS_SRC_HI:`PAS_SRC_LO] = s.src_sel;
				next_s.rdata[`PAS_AC_HI:`PAS_AC_LO] = s.ac_level;
				next_s.rdata[`PAS_BD_HI:`PAS_BD_LO] = s.bd_level;
			end else if (hit_restart) begin
				next_s.rdata[`PAS_RESTART_BIT] = s.restart;
				next_s.rdata[`PAS_DEAD_HI:0] = s.deadband;
			end else if (hit_mode) begin
				next_s.rdata[7:0] = s.mode;
			end else if (hit_dir) begin
				next_s.rdata[3:0] = s.dir;
			end else if (hit_status) begin
				next_s.rdata[`PAS_ST_PERIOD_BIT] = s.period_flag;
				next_s.rdata[`PAS_ST_SRC_BIT] = src_active;
				next_s.rdata[`PAS_ST_HELD_BIT] = s.held;
				next_s.rdata[`PAS_ST_FORCED_BIT] = s.forced;
				next_s.rdata[`PAS_ST_COMP1_BIT] = src_lvl.comp1;
				next_s.rdata[`PAS_ST_COMP2_BIT] = src_lvl.comp2;
				next_s.rdata[`PAS_ST_FAULT_BIT] = src_lvl.fault;
			end
		end

		// Configuration writes
		if (shdn_wr) begin
			next_s.src_sel = pas_src_t'(wbyte[`PAS_SRC_HI:`PAS_SRC_LO]);
			next_s.ac_level = wbyte[`PAS_AC_HI:`PAS_AC_LO];
			next_s.bd_level = wbyte[`PAS_BD_HI:`PAS_BD_LO];
		end
		if (wr_lane0 && hit_restart) begin
			next_s.restart = wbyte[`PAS_RESTART_BIT];
			next_s.deadband = wbyte[`PAS_DEAD_HI:0];
		end
		if (wr_lane0 && hit_mode) begin
			next_s.mode = wbyte;
		end
		if (wr_lane0 && hit_dir) begin
			next_s.dir = wbyte[3:0];
		end

		// Automatic restart once the cause is gone, unless software forced it
		if (s.restart && !src_active && !s.forced) begin
			next_s.flag = 1'b0;
		end

		// Software write to the flag only while no cause is active
		if (shdn_wr && !src_active) begin
			next_s.flag = wbyte[`PAS_FLAG_BIT];
			next_s.forced = wbyte[`PAS_FLAG_BIT];
		end

		// An active cause sets the flag and holds it; set wins over any clear
		if (src_active) begin
			next_s.flag = 1'b1;
		end

		// Outputs leave shutdown only at a period start with the flag clear
		if (s.flag || src_active) begin
			next_s.held = 1'b1;
		end else if (PERIOD_START_IN) begin
			next_s.held = 1'b0;
		end

		// Period flag: set on each period start, write one to clear; set wins
		if (wr_lane0 && hit_status && wbyte[`PAS_ST_PERIOD_BIT]) begin
			next_s.period_flag = 1'b0;
		end
		if (PERIOD_START_IN) begin
			next_s.period_flag = 1'b1;
		end

		// Registered pins
		next_s.pin = pin_val;
		next_s.oe = pin_oe;
	end

	// ==========================================================
	// State register
	always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			s.ack <= 1'b0;
			s.rdata <= 32'h0;
			s.flag <= 1'(`PAS_SHDN_RST >> `PAS_FLAG_BIT);
			s.forced <= 1'b0;
			s.held <= 1'b0;
			s.src_sel <= pas_src_t'(3'(`PAS_SHDN_RST >> `PAS_SRC_LO));
			s.ac_level <= 2'(`PAS_SHDN_RST >> `PAS_AC_LO);
			s.bd_level <= 2'(`PAS_SHDN_RST >> `PAS_BD_LO);
			s.restart <= 1'(`PAS_RESTART_RST >> `PAS_RESTART_BIT);
			s.deadband <= 7'(`PAS_RESTART_RST);
			s.mode <= `PAS_MODE_RST;
			s.dir <= `PAS_DIR_RST;
			s.period_flag <= 1'b0;
			s.pin <= 4'h0;
			s.oe <= 4'h0;
		end else begin
			s <= next_s;
		end
	end

	// ==========================================================
	// Outputs
	always_comb begin
		WB_ACK_OUT = s.ack;
		WB_DAT_OUT = s.rdata;
		PWM_PIN_OUT = s.pin;
		PWM_OE_OUT = s.oe;
		SHUTDOWN_OUT = s.held;
	end

endmodule

// File: pas_top_monitor.sv
// Assertion checker for the PWM auto-shutdown block
`timescale 1ns/100ps
`include "pas_params.svh"
module pas_mon
	import pas_pkg::*;
#(
	parameter int ADDR_W = 8,
	parameter int PINS = 4
) (
	// Clock, reset and bus
	input wire logic CLK_IN,
	input wire logic RST_B_IN,
	input wire logic WB_CYC_IN,
	input wire logic WB_STB_IN,
	input wire logic WB_WE_IN,
	input wire logic [ADDR_W-1:0] WB_ADR_IN,
	input wire logic [3:0] WB_SEL_IN,
	input wire logic [31:0] WB_DAT_IN,
	input wire logic WB_ACK_OUT,
	// Period and sources
	input wire logic PERIOD_START_IN,
	input wire logic COMP1_IN,
	input wire logic FAULT_B_IN,
	// Pins and status
	input wire logic [PINS-1:0] PWM_PIN_OUT,
	input wire logic [PINS-1:0] PWM_OE_OUT,
	input wire logic SHUTDOWN_OUT
);
	// ==========
	// Shadow of the source and level fields
	logic [6:0] shd;
	logic wr;
	assign wr = WB_ACK_OUT && WB_WE_IN && WB_SEL_IN[0] && WB_ADR_IN == `PAS_OFF_SHDN;
	always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			shd <= 7'h00;
		end else if (wr) begin
			shd <= WB_DAT_IN[6:0];
		end
	end
	default clocking @(posedge CLK_IN); endclocking
	default disable iff (!RST_B_IN);
	// ==========
	// Properties
	ack_one_a: assert property (WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT |=> WB_ACK_OUT)
		else $error("ack missing");
	ack_drop_a: assert property (WB_ACK_OUT |=> !WB_ACK_OUT)
		else $error("ack too long");
	reset_idle_a: assert property (!$past(RST_B_IN) |-> PWM_OE_OUT == '0 && !SHUTDOWN_OUT)
		else $error("pins driven after reset");
	fault_hold_a: assert property ((!FAULT_B_IN && shd[6]) [*5] |-> SHUTDOWN_OUT)
		else $error("fault pin ignored");
	cmp_hold_a: assert property ((COMP1_IN && shd[4]) [*5] |-> SHUTDOWN_OUT)
		else $error("comparator ignored");
	sd_ac_a: assert property (SHUTDOWN_OUT && $past(SHUTDOWN_OUT) && $stable(shd)
		|-> (shd[3] ? !PWM_OE_OUT[0] : !PWM_OE_OUT[0] || PWM_PIN_OUT[0] == shd[2]))
		else $error("pair A/C level wrong");
	sd_bd_a: assert property (SHUTDOWN_OUT && $past(SHUTDOWN_OUT) && $stable(shd)
		|-> (shd[1] ? !PWM_OE_OUT[1] : !PWM_OE_OUT[1] || PWM_PIN_OUT[1] == shd[0]))
		else $error("pair B/D level wrong");
	resume_edge_a: assert property ($fell(SHUTDOWN_OUT) |-> $past(PERIOD_START_IN))
		else $error("resume off period start");
	force_set_a: assert property (wr && WB_DAT_IN[7] |-> ##[1:3] SHUTDOWN_OUT)
		else $error("forced shutdown missing");
	cover property (SHUTDOWN_OUT && shd[3]);
	cover property ($fell(SHUTDOWN_OUT));
	cover property (wr && WB_DAT_IN[7]);
endmodule

// File: pas_bridge.sv
// Model of the external bridge switches
`timescale 1ns/100ps
module pas_bridge (
	// Pin drive
	input wire logic [3:0] pin_in,
	input wire logic [3:0] oe_in,
	// Switch gates
	output logic [3:0] gate_out
);
	// A released pin is pulled low so its switch stays off
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			gate_out[i] = oe_in[i] ? pin_in[i] : 1'h0;
		end
	end
endmodule

// File: pas_top_bench.sv
// Self-checking bench for the PWM auto-shutdown block
`timescale 1ns/100ps
`include "pas_params.svh"
module pas_top_bench;
	import pas_pkg::*;
	logic clk = 1'h0;
	logic rst_b = 1'h0;
	logic cyc = 1'h0;
	logic stb = 1'h0;
	logic we = 1'h0;
	logic ps = 1'h0;
	logic c1 = 1'h0;
	logic c2 = 1'h0;
	logic flt_b = 1'h1;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'h0;
	logic [3:0] pwm = 4'h3;
	logic [31:0] wd = 32'h0;
	logic [31:0] rdat, q;
	logic ack, sd;
	logic [3:0] pin, oe, gate;
	logic [15:0] rv [5] = '{16'h0000, 16'h0400, 16'h0800, 16'h0c0f, 16'h2000};
	int err_total = 0;
	int comparisons = 0;
	pas_top uut (.CLK_IN(clk), .RST_B_IN(rst_b), .WB_CYC_IN(cyc), .WB_STB_IN(stb),
		.WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(wd), .WB_DAT_OUT(rdat),
		.WB_ACK_OUT(ack), .PWM_IN(pwm), .PERIOD_START_IN(ps), .COMP1_IN(c1), .COMP2_IN(c2),
		.FAULT_B_IN(flt_b), .PWM_PIN_OUT(pin), .PWM_OE_OUT(oe), .SHUTDOWN_OUT(sd));
	pas_bridge sw (.pin_in(pin), .oe_in(oe), .gate_out(gate));
	initial forever #4 clk = ~clk;
	// ==========
	// Bus and check tasks
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		cyc <= 1'h1;
		stb <= 1'h1;
		we <= w;
		adr <= a;
		wd <= d;
		sel <= 4'hf;
		@(posedge clk);
		while (ack !== 1'h1) begin
			@(posedge clk);
		end
		q = rdat;
		cyc <= 1'h0;
		stb <= 1'h0;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		wb(1'h0, a, 32'h0);
		chk(q, exp);
	endtask
	task automatic period();
		@(posedge clk);
		ps <= 1'h1;
		@(posedge clk);
		ps <= 1'h0;
		repeat (2) @(posedge clk);
	endtask
	task automatic give_verdict();
		if (err_total == 0 && comparisons > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	initial begin
		#100000;
		err_total++;
		give_verdict();
	end
	// ==========
	// Tests
	initial begin
		repeat (16) @(posedge clk);
		rst_b <= 1'h1;
		foreach (rv[i]) rdchk(rv[i][15:8], {24'h0, rv[i][7:0]});
		chk({28'h0, oe}, 32'h0);
		wb(1'h1, `PAS_OFF_MODE, 32'h01);
		wb(1'h1, `PAS_OFF_SHDN, 32'hc4);
		wb(1'h1, `PAS_OFF_RESTART, 32'h80);
		wb(1'h1, `PAS_OFF_STATUS, 32'h01);
		period();
		wb(1'h0, `PAS_OFF_STATUS, 32'h0);
		chk(q & 32'h1, 32'h1);
		wb(1'h1, `PAS_OFF_DIR, 32'h0);
		wb(1'h1, `PAS_OFF_SHDN, 32'h44);
		period();
		chk({28'h0, gate}, 32'h6);
		// Fault pin with automatic restart
		flt_b <= 1'h0;
		repeat (6) @(posedge clk);
		chk({31'h0, sd}, 32'h1);
		chk({28'h0, gate}, 32'h5);
		rdchk(`PAS_OFF_STATUS, 32'h07);
		wb(1'h1, `PAS_OFF_SHDN, 32'h44);
		rdchk(`PAS_OFF_SHDN, 32'hc4);
		flt_b <= 1'h1;
		repeat (6) @(posedge clk);
		rdchk(`PAS_OFF_SHDN, 32'h44);
		chk({31'h0, sd}, 32'h1);
		period();
		chk({31'h0, sd}, 32'h0);
		// Every level code, comparator source, no restart
		wb(1'h1, `PAS_OFF_RESTART, 32'h0);
		for (int lv = 0; lv < 4; lv++) begin
			wb(1'h1, `PAS_OFF_SHDN, 32'h10 | 32'(lv * 5));
			c1 <= 1'h1;
			repeat (6) @(posedge clk);
			chk({28'h0, gate}, lv[1] ? 32'h0 : {28'h0, {4{lv[0]}}});
			chk({28'h0, oe}, lv[1] ? 32'h0 : 32'hf);
			wb(1'h1, `PAS_OFF_SHDN, 32'h10 | 32'(lv * 5));
			rdchk(`PAS_OFF_SHDN, 32'h90 | 32'(lv * 5));
			c1 <= 1'h0;
			repeat (6) @(posedge clk);
			rdchk(`PAS_OFF_SHDN, 32'h90 | 32'(lv * 5));
			wb(1'h1, `PAS_OFF_SHDN, 32'h10 | 32'(lv * 5));
			period();
			chk({31'h0, sd}, 32'h0);
		end
		// Every source code against each single source
		wb(1'h1, `PAS_OFF_RESTART, 32'h80);
		for (int s = 0; s < 8; s++) begin
			for (int k = 0; k < 3; k++) begin
				wb(1'h1, `PAS_OFF_SHDN, 32'(s << 4));
				c1 <= (k == 0);
				c2 <= (k == 1);
				flt_b <= (k != 2);
				repeat (6) @(posedge clk);
				rdchk(`PAS_OFF_SHDN, 32'(s << 4) | (s[k] ? 32'h80 : 32'h0));
				c1 <= 1'h0;
				c2 <= 1'h0;
				flt_b <= 1'h1;
				repeat (6) @(posedge clk);
			end
		end
		// Forced shutdown without a source
		wb(1'h1, `PAS_OFF_SHDN, 32'h80);
		repeat (3) @(posedge clk);
		chk({31'h0, sd}, 32'h1);
		rdchk(`PAS_OFF_SHDN, 32'h80);
		wb(1'h1, `PAS_OFF_SHDN, 32'h0);
		period();
		chk({31'h0, sd}, 32'h0);
		// Pins as inputs, then pair B/D active low, then pins driven again
		wb(1'h1, `PAS_OFF_DIR, 32'hf);
		repeat (2) @(posedge clk);
		chk({28'h0, oe}, 32'h0);
		wb(1'h1, `PAS_OFF_MODE, 32'h02);
		wb(1'h1, `PAS_OFF_DIR, 32'h0);
		repeat (2) @(posedge clk);
		chk({28'h0, gate}, 32'h9);
		chk({28'h0, oe}, 32'hf);
		give_verdict();
	end
endmodule
bind pas_top pas_mon #(.ADDR_W(ADDR_W), .PINS(PINS)) mon (.CLK_IN(CLK_IN),
	.RST_B_IN(RST_B_IN), .WB_CYC_IN(WB_CYC_IN), .WB_STB_IN(WB_STB_IN), .WB_WE_IN(WB_WE_IN),
	.WB_ADR_IN(WB_ADR_IN), .WB_SEL_IN(WB_SEL_IN), .WB_DAT_IN(WB_DAT_IN),
	.WB_ACK_OUT(WB_ACK_OUT), .PERIOD_START_IN(PERIOD_START_IN), .COMP1_IN(COMP1_IN),
	.FAULT_B_IN(FAULT_B_IN), .PWM_PIN_OUT(PWM_PIN_OUT), .PWM_OE_OUT(PWM_OE_OUT),
	.SHUTDOWN_OUT(SHUTDOWN_OUT));
